// [rtl/dcc_driver_chip_control_regs.sv]
// serial slave and register bank for the bridge driver companion chip
// assumes pins asynchronous to clk; serial clock far slower than clk
`default_nettype none
module dcc_driver_chip_control_regs (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // reset sources
  input wire logic porRequest,
  input wire logic porRelease,
  input wire logic extResetRequest,
  // serial pins
  input wire logic serialSelectPin,
  input wire logic serialClockPin,
  input wire logic serialDataIn,
  input wire logic sleepControlPin,
  output logic serialDataOut,
  output logic serialDataOutEn,
  // fault inputs and pwm source
  input wire logic driverKillInput,
  input wire logic overheatDetect,
  input wire logic lineDriverOvercurrent,
  input wire logic sensorSupplyOvercurrent,
  input wire logic regulatorUndervoltage,
  input wire logic [5:0] channelOvercurrent,
  input wire logic pwmSourcePin,
  // driver controls
  output logic [5:0] channelHighSideOn,
  output logic [5:0] channelLowSideOn,
  output logic bridgeEnable,
  output logic sensorSupplyEnable
);
  localparam int NSYNC = 18;  // async inputs except porRequest brought through two flops

  typedef struct packed {
    logic [NSYNC-1:0] syncA;
    logic [NSYNC-1:0] syncB;
    logic sckPrev;
    logic selPrev;
    logic [2:0] bitCnt;
    logic [1:0] byteCnt;
    logic [7:0] shiftIn;
    logic [7:0] shiftOut;
    logic [7:0] headByte;
    logic [15:0] dataWord;
    logic headDone;
    logic [7:0] sysCtrl;
    logic [7:0] faultStat;
    logic [7:0] sysStat;
    logic [7:0] gating;
    logic [15:0] bridgeCtrl;
    logic [7:0] resetCause;
    logic sdo;
    logic sdoEn;
    logic [5:0] hiOut;
    logic [5:0] loOut;
    logic enOut;
    logic svOut;
  } dcc_state_s;

  dcc_state_s state_reg, state_next;

  logic [NSYNC-1:0] rawIn;
  logic [NSYNC-1:0] s;
  assign rawIn = {channelOvercurrent, pwmSourcePin, regulatorUndervoltage,
    sensorSupplyOvercurrent, lineDriverOvercurrent, overheatDetect, driverKillInput,
    sleepControlPin, serialDataIn, serialClockPin, serialSelectPin, extResetRequest,
    porRelease};
  assign s = state_reg.syncB;

  // named views of synchronised inputs
  logic porRel, extRst, sel, sck, sdi, sleepHigh, killHigh, ovh, lineOc, sensOc, uv, pwm;
  logic [5:0] chOc;
  assign porRel = s[0];
  assign extRst = s[1];
  assign sel = s[2];
  assign sck = s[3];
  assign sdi = s[4];
  assign sleepHigh = s[5];
  assign killHigh = s[6];
  assign ovh = s[7];
  assign lineOc = s[8];
  assign sensOc = s[9];
  assign uv = s[10];
  assign pwm = s[11];
  assign chOc = s[17:12];

  // ==========================================================
  // next state
  always_comb begin
    logic rise, fall, selRise, active, commit, parOk;
    logic [4:0] addr;
    logic [7:0] wb;
    logic [15:0] ww, hb;
    logic [5:0] clrGrp;
    logic [7:0] rd;
    state_next = state_reg;
    rise = 1'b0;
    fall = 1'b0;
    selRise = 1'b0;
    active = 1'b0;
    commit = 1'b0;
    parOk = 1'b0;
    addr = 5'h00;
    wb = 8'h00;
    ww = 16'h0000;
    hb = 16'h0000;
    clrGrp = 6'h00;
    rd = 8'h00;
    state_next.syncA = rawIn;
    state_next.syncB = state_reg.syncA;
    state_next.sckPrev = sck;
    state_next.selPrev = sel;
    active = sleepHigh && !sel;
    rise = sck && !state_reg.sckPrev;
    fall = !sck && state_reg.sckPrev;
    selRise = sel && !state_reg.selPrev;
    addr = state_reg.headByte[6:2];
    // read mux for the addressed register
    case (addr)
      dcc_pkg::ADDR_SYSTEM_CONTROL: rd = state_reg.sysCtrl;
      dcc_pkg::ADDR_BRIDGE_FAULT_STATUS: rd = state_reg.faultStat;
      dcc_pkg::ADDR_SYSTEM_STATUS: rd = state_reg.sysStat;
      dcc_pkg::ADDR_PWM_GATING_CONTROL: rd = state_reg.gating;
      // high byte leaves first, while no data byte has completed yet
      dcc_pkg::ADDR_BRIDGE_OUTPUT_CONTROL: rd = (state_reg.byteCnt == 2'h0) ?
        state_reg.bridgeCtrl[15:8] : state_reg.bridgeCtrl[7:0];
      dcc_pkg::ADDR_RESET_CAUSE_STATUS: rd = state_reg.resetCause;
      default: rd = 8'h00;
    endcase
    // serial shifter, msb first
    if (!active) begin
      state_next.bitCnt = 3'h0;
      state_next.sdoEn = 1'b0;
      if (!sleepHigh || selRise) begin
        state_next.byteCnt = 2'h0;
        state_next.headDone = 1'b0;
      end
    end else begin
      state_next.sdoEn = 1'b1;
      if (fall) begin
        state_next.shiftIn = {state_reg.shiftIn[6:0], sdi};
        state_next.bitCnt = state_reg.bitCnt + 3'h1;
        if (state_reg.bitCnt == dcc_pkg::BIT_CNT_LAST) begin
          if (!state_reg.headDone) begin
            state_next.headByte = {state_reg.shiftIn[6:0], sdi};
            state_next.headDone = 1'b1;
          end else begin
            state_next.dataWord = {state_reg.dataWord[7:0], state_reg.shiftIn[6:0], sdi};
            state_next.byteCnt = state_reg.byteCnt + 2'h1;
          end
        end
      end
      if (rise) begin
        if (state_reg.bitCnt == 3'h0 && state_reg.headDone) begin
          state_next.sdo = rd[7];
          state_next.shiftOut = {rd[6:0], 1'b0};
        end else begin
          state_next.sdo = state_reg.shiftOut[7];
          state_next.shiftOut = {state_reg.shiftOut[6:0], 1'b0};
        end
      end
    end
    // even parity over rw and address
    parOk = ~^state_reg.headByte[7:1];
    commit = selRise && state_reg.headDone && state_reg.headByte[dcc_pkg::FRAME_RW]
      && state_reg.byteCnt != 2'h0 && sleepHigh;
    wb = state_reg.dataWord[7:0];
    ww = state_reg.dataWord;
    if (selRise && state_reg.headDone && state_reg.headByte[dcc_pkg::FRAME_RW]
        && !parOk && sleepHigh)
      state_next.sysStat[dcc_pkg::BIT_PARITY] = 1'b1;
    if (commit && parOk) begin
      case (addr)
        dcc_pkg::ADDR_SYSTEM_CONTROL: state_next.sysCtrl = wb & dcc_pkg::MASK_CONTROL;
        dcc_pkg::ADDR_BRIDGE_FAULT_STATUS:
          state_next.faultStat = state_reg.faultStat & wb;
        dcc_pkg::ADDR_SYSTEM_STATUS:
          state_next.sysStat = state_next.sysStat & (wb | ~dcc_pkg::MASK_STATUS_STICKY);
        dcc_pkg::ADDR_PWM_GATING_CONTROL:
          if (!state_reg.sysStat[dcc_pkg::BIT_OVERHEAT] && killHigh)
            state_next.gating = wb & dcc_pkg::MASK_GATING;
        dcc_pkg::ADDR_BRIDGE_OUTPUT_CONTROL:
          if (!state_reg.sysStat[dcc_pkg::BIT_OVERHEAT] && killHigh) begin
            hb = ww & dcc_pkg::MASK_BRIDGE;
            for (int i = 0; i < dcc_pkg::NUM_CHAN; i++) begin
              if (hb[dcc_pkg::CHAN_LSB_BRIDGE + 2*i +: 2] == 2'h3)
                hb[dcc_pkg::CHAN_LSB_BRIDGE + 2*i +: 2] =
                  state_reg.bridgeCtrl[dcc_pkg::CHAN_LSB_BRIDGE + 2*i +: 2];
            end
            state_next.bridgeCtrl = hb;
          end
        dcc_pkg::ADDR_RESET_CAUSE_STATUS:
          if (!wb[dcc_pkg::BIT_EXTERNAL_RESET])
            state_next.resetCause[dcc_pkg::BIT_EXTERNAL_RESET] = 1'b0;
        default: ;
      endcase
    end
    // sticky event flags: set wins over clear
    if (lineOc) state_next.sysStat[dcc_pkg::BIT_LINE_OC] = 1'b1;
    if (sensOc) state_next.sysStat[dcc_pkg::BIT_SENSOR_OC] = 1'b1;
    if (ovh) state_next.sysStat[dcc_pkg::BIT_OVERHEAT] = 1'b1;
    state_next.sysStat[dcc_pkg::BIT_UNDERVOLT] = uv;
    state_next.sysStat[0] = 1'b0;
    // channel overcurrent protection
    if (state_reg.sysCtrl[dcc_pkg::BIT_GROUP_SELECT])
      clrGrp = (|chOc) ? 6'h3F : 6'h00;
    else
      clrGrp = {{3{|chOc[5:3]}}, {3{|chOc[2:0]}}};
    for (int i = 0; i < dcc_pkg::NUM_CHAN; i++) begin
      if (chOc[i]) state_next.faultStat[dcc_pkg::CHAN_LSB_GATE + i] = 1'b1;
      if (clrGrp[i]) begin
        state_next.gating[dcc_pkg::CHAN_LSB_GATE + i] = 1'b0;
        state_next.bridgeCtrl[dcc_pkg::CHAN_LSB_BRIDGE + 2*i +: 2] = 2'h0;
      end
    end
    state_next.faultStat[1:0] = 2'h0;
    state_next.sysStat[dcc_pkg::BIT_GROUP_A_OC] =
      |state_next.faultStat[dcc_pkg::CHAN_LSB_GATE +: 3];
    state_next.sysStat[dcc_pkg::BIT_GROUP_B_OC] =
      |state_next.faultStat[dcc_pkg::CHAN_LSB_GATE + 3 +: 3];
    // forced clears of driver controls
    if (ovh || !killHigh) begin
      state_next.bridgeCtrl = dcc_pkg::RESET_WORD;
      state_next.gating = dcc_pkg::RESET_BYTE;
    end
    // reset cause flags
    if (extRst) state_next.resetCause[dcc_pkg::BIT_EXTERNAL_RESET] = 1'b1;
    if (porRel) state_next.resetCause[dcc_pkg::BIT_POWER_ON_RELEASE] = 1'b1;
    // chip reset by external request clears all except reset cause
    if (extRst) begin
      state_next.sysCtrl = dcc_pkg::RESET_BYTE;
      state_next.faultStat = dcc_pkg::RESET_BYTE;
      state_next.sysStat = dcc_pkg::RESET_BYTE;
      state_next.gating = dcc_pkg::RESET_BYTE;
      state_next.bridgeCtrl = dcc_pkg::RESET_WORD;
    end
    // output stage
    for (int i = 0; i < dcc_pkg::NUM_CHAN; i++) begin
      state_next.hiOut[i] = state_next.bridgeCtrl[dcc_pkg::CHAN_LSB_BRIDGE + 2*i + 1];
      state_next.loOut[i] = state_next.bridgeCtrl[dcc_pkg::CHAN_LSB_BRIDGE + 2*i]
        | (state_next.gating[dcc_pkg::CHAN_LSB_GATE + i] & pwm);
    end
    state_next.enOut = state_next.sysCtrl[dcc_pkg::BIT_BRIDGE_ENABLE];
    state_next.svOut = state_next.sysCtrl[dcc_pkg::BIT_SENSOR_ENABLE];
  end

  // ==========================================================
  // state register; power-on request clears everything except the select flops, which it sets high
  always_ff @(posedge clk) begin
    if (rst || porRequest) begin
      state_reg <= '0;
      // select idles high: avoids a false select edge after reset
      state_reg.syncA[2] <= 1'b1;
      state_reg.syncB[2] <= 1'b1;
      state_reg.selPrev <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign serialDataOut = state_reg.sdo;
  assign serialDataOutEn = state_reg.sdoEn;
  assign channelHighSideOn = state_reg.hiOut;
  assign channelLowSideOn = state_reg.loOut;
  assign bridgeEnable = state_reg.enOut;
  assign sensorSupplyEnable = state_reg.svOut;
endmodule // dcc_driver_chip_control_regs
`default_nettype wire

// [rtl/dcc_pkg.sv]
// constants of the serial-reached control and status register bank
// assumes a single system clock; all pins arrive asynchronous to it
//
// Functional notes
// - six registers at serial addresses 01010B to 01111B.
// - reset cause register cleared to zero only by power-on reset.
// - bit 7 read-only, set on power-on release, cleared by power-on reset.
// - bit 6 set by external reset pin, cleared by writing 0 or by power-on reset.
// - writes to bridge control ignored while overheat flag is set.
// - bridge control cleared by reset, overheat and low kill input.
// - channel pairs in bits 15..4; 11 prohibited; bits 3..0 read zero.
// - a write setting both sides of a channel keeps that channel's bits.
// - gating enables in bits 7..2 pass pwm pin to low side.
// - writes to gating register ignored while overheat flag is set.
// - gating register cleared by reset, overheat and low kill input.
// - channel overcurrent clears its group, or all when group select is 1.
// - line driver overcurrent flag bit 7, sticky until written 0.
// - bits 6 and 5 are OR of channel flags 1-3 and 4-6.
// - sensor supply overcurrent bit 4, sticky until written 0.
// - bit 3 follows regulator undervoltage level, read-only.
// - overheat bit 2, sticky until written 0.
// - bit 1 set on write frame with wrong parity, sticky.
// - writing 1 to sticky status bits leaves them unchanged.
// - channel overcurrent flags in bits 7..2, cleared by writing 0.
// - control bits: bridge enable 7, sensor enable 6, group select 5.
// - system status, fault status and control cleared by any reset.
// - 8-bit units, msb first, select low; drive rising, sample falling.
// - even parity over write bit and address; commit at select rise.
// - serial interface halts while sleep control is low.
`default_nettype none
package dcc_pkg;
  // ==========================================================
  // register addresses (5-bit serial)
  localparam logic [4:0] ADDR_SYSTEM_CONTROL = 5'h0A;
  localparam logic [4:0] ADDR_BRIDGE_FAULT_STATUS = 5'h0B;
  localparam logic [4:0] ADDR_SYSTEM_STATUS = 5'h0C;
  localparam logic [4:0] ADDR_PWM_GATING_CONTROL = 5'h0D;
  localparam logic [4:0] ADDR_BRIDGE_OUTPUT_CONTROL = 5'h0E;
  localparam logic [4:0] ADDR_RESET_CAUSE_STATUS = 5'h0F;
  // ==========================================================
  // field positions
  localparam int BIT_POWER_ON_RELEASE = 7;
  localparam int BIT_EXTERNAL_RESET = 6;
  localparam int BIT_LINE_OC = 7;
  localparam int BIT_GROUP_A_OC = 6;
  localparam int BIT_GROUP_B_OC = 5;
  localparam int BIT_SENSOR_OC = 4;
  localparam int BIT_UNDERVOLT = 3;
  localparam int BIT_OVERHEAT = 2;
  localparam int BIT_PARITY = 1;
  localparam int BIT_BRIDGE_ENABLE = 7;
  localparam int BIT_SENSOR_ENABLE = 6;
  localparam int BIT_GROUP_SELECT = 5;
  localparam int CHAN_LSB_GATE = 2;
  localparam int CHAN_LSB_BRIDGE = 4;
  localparam int NUM_CHAN = 6;
  // ==========================================================
  // reset values and masks
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [7:0] MASK_CONTROL = 8'hE0;
  localparam logic [7:0] MASK_GATING = 8'hFC;
  localparam logic [15:0] MASK_BRIDGE = 16'hFFF0;
  localparam logic [7:0] MASK_STATUS_STICKY = 8'h96;
  // ==========================================================
  // frame layout: byte0 = rw, addr[4:0], parity, spare
  localparam int FRAME_BITS = 8;
  localparam logic [2:0] BIT_CNT_LAST = 3'h7;
  localparam int FRAME_RW = 7;
  localparam int FRAME_PARITY = 1;
endpackage : dcc_pkg
`default_nettype wire

// [sim/dcc_regs_assertions.sv]
// checker on the register bank pins
// assumes binding onto the bank module
`default_nettype none
module dcc_regs_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // causes and effects
  input wire logic porRequest,
  input wire logic extResetRequest,
  input wire logic serialSelectPin,
  input wire logic sleepControlPin,
  input wire logic driverKillInput,
  input wire logic overheatDetect,
  input wire logic [5:0] channelOvercurrent,
  input wire logic serialDataOutEn,
  input wire logic [5:0] channelHighSideOn,
  input wire logic [5:0] channelLowSideOn,
  input wire logic bridgeEnable
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // properties
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_por_clears: assert property (porRequest [*2] |=>
    {channelHighSideOn, channelLowSideOn, bridgeEnable} == 13'h0000) else $error("por kept");
  chk_kill_clears: assert property (!driverKillInput [*5] |=>
    {channelHighSideOn, channelLowSideOn} == 12'h000) else $error("kill ignored");
  chk_heat_clears: assert property ($rose(overheatDetect) |-> ##[1:6]
    {channelHighSideOn, channelLowSideOn} == 12'h000) else $error("heat ignored");
  chk_group_a: assert property ($rose(channelOvercurrent[0]) |-> ##[1:6]
    channelHighSideOn[2:0] == 3'h0) else $error("group a on");
  chk_group_b: assert property ($rose(channelOvercurrent[3]) |-> ##[1:6]
    channelHighSideOn[5:3] == 3'h0) else $error("group b on");
  chk_sleep_quiet: assert property (!sleepControlPin [*5] |->
    !serialDataOutEn) else $error("drive in sleep");
  chk_idle_quiet: assert property (serialSelectPin [*5] |->
    !serialDataOutEn) else $error("drive unselected");
  chk_bridge_hold: assert property ((serialSelectPin && driverKillInput
    && !overheatDetect && channelOvercurrent == 6'h00 && !porRequest && !extResetRequest) [*8]
    |=> $stable(channelHighSideOn)) else $error("bridge moved");
  // main scenarios
  cover property ($rose(overheatDetect));
  cover property ($fell(serialSelectPin) ##1 sleepControlPin);
  cover property ($rose(channelOvercurrent[3]));
  cover property ($rose(channelOvercurrent[0]));
endmodule // dcc_regs_checker
bind dcc_driver_chip_control_regs dcc_regs_checker chk_i (.clk(clk), .rst(rst),
  .porRequest(porRequest), .extResetRequest(extResetRequest),
  .serialSelectPin(serialSelectPin), .sleepControlPin(sleepControlPin),
  .driverKillInput(driverKillInput), .overheatDetect(overheatDetect),
  .channelOvercurrent(channelOvercurrent), .serialDataOutEn(serialDataOutEn),
  .channelHighSideOn(channelHighSideOn), .channelLowSideOn(channelLowSideOn),
  .bridgeEnable(bridgeEnable));
`default_nettype wire

// [sim/dcc_host_model.sv]
// host serial master model for the register bank
// assumes select idles high, clock idles low, data line pulled down
`default_nettype none
module dcc_host_model (
  // serial pins
  output var logic serialSelectPin,
  output var logic serialClockPin,
  output var logic serialDataIn,
  input wire logic sdoLine
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // idle levels
  initial begin
    serialSelectPin = 1'b1;
    serialClockPin = 1'b0;
    serialDataIn = 1'b0;
  end
  // one frame: head byte then n data bytes, msb first
  task automatic xfer(input logic rw, input logic [4:0] a, input logic flip,
      input logic [15:0] d, input int n, output logic [15:0] q);
    logic [23:0] f;
    f = {rw, a, ^{rw, a} ^ flip, 1'b0, (n == 2) ? d : {d[7:0], 8'h00}};
    q = 16'h0000;
    serialSelectPin = 1'b0;
    #62.5;
    for (int i = 0; i < 8 * n + 8; i++) begin
      serialClockPin = 1'b1;
      serialDataIn = f[23 - i];
      #62.5;
      serialClockPin = 1'b0;
      if (i > 7) q = {q[14:0], sdoLine};
      #62.5;
    end
    serialDataIn = 1'b0;
    serialSelectPin = 1'b1;
    #500;
  endtask
endmodule // dcc_host_model
`default_nettype wire

// [sim/dcc_driver_chip_control_regs_bench.sv]
// self-checking bench for the control register bank
// assumes the host model for frames; fault pins pulsed on falling edges
`default_nettype none
module dcc_driver_chip_control_regs_bench;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // pins and counters
  logic clk = 1'b0, rst = 1'b1, sleepControlPin = 1'b1, driverKillInput = 1'b1;
  logic regulatorUndervoltage = 1'b0, pwmSourcePin = 1'b1;
  logic [11:0] ev = 12'h000;
  wire logic porRequest, porRelease, extResetRequest, overheatDetect, lineDriverOvercurrent;
  wire logic sensorSupplyOvercurrent, serialSelectPin, serialClockPin, serialDataIn, sdoLine;
  wire logic [5:0] channelOvercurrent, channelHighSideOn, channelLowSideOn;
  wire logic serialDataOut, serialDataOutEn, bridgeEnable, sensorSupplyEnable;
  int failures = 0;
  int checks_done = 0;
  // event pulses fan out; released data line floats
  assign {channelOvercurrent, porRequest, porRelease, extResetRequest,
    sensorSupplyOvercurrent, lineDriverOvercurrent, overheatDetect} = ev;
  assign sdoLine = serialDataOutEn ? serialDataOut : 1'bz;
  // clock
  always #5 clk = ~clk;
  dcc_host_model host (.serialSelectPin(serialSelectPin), .serialClockPin(serialClockPin),
    .serialDataIn(serialDataIn), .sdoLine(sdoLine));
  dcc_driver_chip_control_regs uut (.clk(clk), .rst(rst), .porRequest(porRequest),
    .porRelease(porRelease), .extResetRequest(extResetRequest),
    .serialSelectPin(serialSelectPin), .serialClockPin(serialClockPin),
    .serialDataIn(serialDataIn), .sleepControlPin(sleepControlPin),
    .serialDataOut(serialDataOut), .serialDataOutEn(serialDataOutEn),
    .driverKillInput(driverKillInput), .overheatDetect(overheatDetect),
    .lineDriverOvercurrent(lineDriverOvercurrent),
    .sensorSupplyOvercurrent(sensorSupplyOvercurrent),
    .regulatorUndervoltage(regulatorUndervoltage), .channelOvercurrent(channelOvercurrent),
    .pwmSourcePin(pwmSourcePin), .channelHighSideOn(channelHighSideOn),
    .channelLowSideOn(channelLowSideOn), .bridgeEnable(bridgeEnable),
    .sensorSupplyEnable(sensorSupplyEnable));
  // ==========================================================
  // access and compare tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d, input int n, input logic f = 0);
    logic [15:0] q;
    host.xfer(1'b1, a, f, d, n, q);
  endtask
  task automatic rc(input logic [4:0] a, input logic [15:0] e, input int n);
    logic [15:0] q;
    host.xfer(1'b0, a, 1'b0, 16'h0000, n, q);
    chk(q, e);
  endtask
  task automatic pulse(input logic [11:0] m);
    @(negedge clk) ev = m;
    repeat (3) @(negedge clk);
    ev = 12'h000;
    repeat (4) @(negedge clk);
  endtask
  task automatic final_report();
    $display("checks %0d, failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    final_report();
  end
  // main sequence
  initial begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    for (int a = 10; a < 16; a++) rc(5'(a), 16'h0000, (a == 14) ? 2 : 1);
    chk({15'h0000, serialDataOutEn}, 16'h0000);
    wr(5'h0A, 16'h00FF, 1);
    rc(5'h0A, 16'h00E0, 1);
    chk({14'h0000, bridgeEnable, sensorSupplyEnable}, 16'h0003);
    wr(5'h0E, 16'h002F, 2);
    wr(5'h0E, 16'h0030, 2);
    rc(5'h0E, 16'h0020, 2);
    wr(5'h0D, 16'h00FF, 1);
    rc(5'h0D, 16'h00FC, 1);
    chk({4'h0, channelHighSideOn, channelLowSideOn}, 16'h007F);
    pulse(12'h001);
    rc(5'h0D, 16'h0000, 1);
    wr(5'h0E, 16'h0020, 2);
    rc(5'h0E, 16'h0000, 2);
    wr(5'h0C, 16'h00FF, 1);
    rc(5'h0C, 16'h0004, 1);
    wr(5'h0C, 16'h0000, 1, 1'b1);
    rc(5'h0C, 16'h0006, 1);
    wr(5'h0C, 16'h0000, 1);
    @(negedge clk) regulatorUndervoltage = 1'b1;
    pulse(12'h006);
    rc(5'h0C, 16'h0098, 1);
    @(negedge clk) regulatorUndervoltage = 1'b0;
    wr(5'h0A, 16'h00C0, 1);
    wr(5'h0E, 16'hAAA0, 2);
    wr(5'h0D, 16'h00FC, 1);
    pulse(12'h200);
    rc(5'h0E, 16'h02A0, 2);
    rc(5'h0D, 16'h001C, 1);
    rc(5'h0B, 16'h0020, 1);
    rc(5'h0C, 16'h00B0, 1);
    wr(5'h0B, 16'h00FF, 1);
    rc(5'h0B, 16'h0020, 1);
    pulse(12'h040);
    rc(5'h0E, 16'h0000, 2);
    rc(5'h0B, 16'h0024, 1);
    @(negedge clk) driverKillInput = 1'b0;
    rc(5'h0E, 16'h0000, 2);
    @(negedge clk) driverKillInput = 1'b1;
    @(negedge clk) sleepControlPin = 1'b0;
    wr(5'h0A, 16'h0000, 1);
    @(negedge clk) sleepControlPin = 1'b1;
    rc(5'h0A, 16'h00C0, 1);
    pulse(12'h008);
    rc(5'h0F, 16'h0040, 1);
    pulse(12'h010);
    wr(5'h0F, 16'h0000, 1);
    rc(5'h0F, 16'h0080, 1);
    pulse(12'h020);
    rc(5'h0F, 16'h0000, 1);
    final_report();
  end
endmodule // dcc_driver_chip_control_regs_bench
`default_nettype wire
